// ### tpi_pkg.sv
// constants, field layouts and state types of the transmit character input block
// assumes a 100 MHz core clock and a 32-bit avalon-mm register slave
package tpi_pkg;

    // timing
    localparam int CLK_MHZ         = 100;
    localparam int REF_LOSS_NS     = 1000;
    localparam int REF_LOSS_CYC    = (REF_LOSS_NS * CLK_MHZ) / 1000;
    localparam int BUILT_IN_SELFTEST_PERIOD_RX  = 527;
    localparam int BUILT_IN_SELFTEST_PERIOD_REF = 511;

    // phase align buffer
    localparam int PAB_DEPTH       = 4;
    localparam logic [2:0] PAB_CENTER = 3'h2;

    // register byte offsets
    localparam logic [4:0] REG_CTRL     = 5'h00;
    localparam logic [4:0] REG_RECENTER = 5'h04;
    localparam logic [4:0] REG_STATUS   = 5'h08;
    localparam logic [4:0] REG_EVENTS   = 5'h0c;
    localparam logic [4:0] REG_MASK     = 5'h10;

    // control register fields
    localparam int CTRL_TX_CLK_SEL   = 0;
    localparam int CTRL_RX_CLK_SEL   = 1;
    localparam int CTRL_SELFTEST_EN  = 2;
    localparam int CTRL_OUT1_EN      = 3;
    localparam int CTRL_OUT2_EN      = 4;
    localparam int CTRL_ENC_BYPASS   = 5;
    localparam int CTRL_HALF_RATE    = 6;
    localparam logic [6:0] CTRL_RESET = 7'h1c;

    // event register fields
    localparam int EV_OVERFLOW  = 0;
    localparam int EV_UNDERFLOW = 1;
    localparam int EV_BUILT_IN_SELFTEST_PASS = 2;
    localparam int EV_REF_LOSS  = 3;

    typedef enum logic [1:0] {
        TPI_KIND_DATA    = 2'b00,
        TPI_KIND_SPECIAL = 2'b01,
        TPI_KIND_REPLACE = 2'b10,
        TPI_KIND_RAW     = 2'b11
    } tpi_kind_t;

    typedef enum logic [0:0] {
        TPI_BUS_IDLE   = 1'b0,
        TPI_BUS_ANSWER = 1'b1
    } tpi_bus_t;

    typedef struct packed {
        tpi_kind_t   kind;
        logic [9:0]  code;
    } tpi_char_t;

    typedef struct packed {
        logic f1;
        logic f2;
        logic f3;
        logic stable;
    } tpi_sync_t;

    typedef struct packed {
        tpi_bus_t                    bus;
        logic                        waitreq;
        logic [31:0]                 rdata;
        logic [6:0]                  ctrl;
        logic                        recenter;
        logic [3:0]                  events;
        logic [3:0]                  mask;
        logic                        irq;
        tpi_sync_t                   txc;
        tpi_sync_t                   refc;
        tpi_sync_t                   rxc;
        logic [9:0]                  din1;
        logic [9:0]                  din2;
        logic [9:0]                  din3;
        logic [PAB_DEPTH-1:0][9:0]   mem;
        logic [1:0]                  wr_ptr;
        logic [1:0]                  rd_ptr;
        logic [2:0]                  fill;
        logic                        pab_err;
        logic [9:0]                  built_in_selftest_cnt;
        logic                        built_in_selftest_pulse;
        logic [7:0]                  ref_idle;
        tpi_char_t                   char_out;
        logic                        char_valid;
        logic                        err;
    } tpi_state_t;

endpackage : tpi_pkg

// ### tpi_tx_input.sv
// transmit parallel character input, phase align buffer and transmit error output
// assumes clock pins and character pins are asynchronous to core_clk, and that
// word_sync_sent comes from core_clk logic of the encoder side
`timescale 1ns/100ps

module tpi_tx_input
    import tpi_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        tx_input_clock,
    input  wire logic        ref_clock,
    input  wire logic        rx_recovered_clock,
    input  wire logic [7:0]  tx_char_in,
    input  wire logic [1:0]  tx_ctrl_in,
    input  wire logic        word_sync_sent,
    output tpi_char_t        enc_char_out,
    output logic             enc_char_valid,
    output logic             tx_error_flag,
    output logic             irq
);

    localparam logic [9:0] BUILT_IN_SELFTEST_LAST_RX  = 10'(BUILT_IN_SELFTEST_PERIOD_RX - 1);
    localparam logic [9:0] BUILT_IN_SELFTEST_LAST_REF = 10'(BUILT_IN_SELFTEST_PERIOD_REF - 1);
    localparam logic [7:0] REF_LOSS_LIM  = 8'(REF_LOSS_CYC);
    localparam logic [2:0] PAB_FULL      = 3'(PAB_DEPTH);

    tpi_state_t s_q;
    tpi_state_t s_d;

    // three-stage sampler; a level counts once stages two and three agree
    function automatic tpi_sync_t sync_next(input tpi_sync_t s, input logic pin);
        tpi_sync_t n;
        n.f1     = pin;
        n.f2     = s.f1;
        n.f3     = s.f2;
        n.stable = (s.f2 == s.f3) ? s.f3 : s.stable;
        return n;
    endfunction : sync_next

    // character-rate tick from the reference sampler; both edges at half rate
    function automatic logic ref_tick(input logic rise, input logic fall, input logic half);
        return rise | (half & fall);
    endfunction : ref_tick

    function automatic logic [31:0] read_mux(input tpi_state_t s, input logic [4:0] a);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            REG_CTRL:     v = {25'h0, s.ctrl};
            REG_RECENTER: v = {31'h0, s.recenter};
            REG_STATUS:   v = {27'h0, s.fill, s.pab_err, s.err};
            REG_EVENTS:   v = {28'h0, s.events};
            REG_MASK:     v = {28'h0, s.mask};
            default:      v = 32'h0;
        endcase
        return v;
    endfunction : read_mux

    logic        tx_rise;
    logic        ref_rise;
    logic        ref_fall;
    logic        rx_rise;
    logic        if_tick;
    logic        char_tick;
    logic        do_write;
    logic        do_read;
    logic        recenter_now;
    logic        push_ok;
    logic        pop_ok;
    logic        overflow;
    logic        underflow;
    logic        built_in_selftest_wrap;
    logic        ref_lost;
    logic        pll_down;
    logic [3:0]  ev_set;
    logic [9:0]  pop_word;
    logic [9:0]  built_in_selftest_last;

    always_comb begin
        s_d = s_q;

        // pin sampling
        s_d.txc  = sync_next(s_q.txc, tx_input_clock);
        s_d.refc = sync_next(s_q.refc, ref_clock);
        s_d.rxc  = sync_next(s_q.rxc, rx_recovered_clock);
        s_d.din1 = {tx_ctrl_in, tx_char_in};
        s_d.din2 = s_q.din1;
        s_d.din3 = s_q.din2;

        tx_rise  = s_d.txc.stable & ~s_q.txc.stable;
        ref_rise = s_d.refc.stable & ~s_q.refc.stable;
        ref_fall = ~s_d.refc.stable & s_q.refc.stable;
        rx_rise  = s_d.rxc.stable & ~s_q.rxc.stable;

        // interface clock choice
        if (s_q.ctrl[CTRL_TX_CLK_SEL]) begin
            if_tick = ref_tick(ref_rise, ref_fall, s_q.ctrl[CTRL_HALF_RATE]);
        end else begin
            if_tick = tx_rise;
        end

        // internal character clock
        if (s_q.ctrl[CTRL_RX_CLK_SEL]) begin
            char_tick = rx_rise;
        end else begin
            char_tick = ref_tick(ref_rise, ref_fall, s_q.ctrl[CTRL_HALF_RATE]);
        end

        // register bus: answer one cycle after a request is seen
        do_write     = 1'b0;
        do_read      = 1'b0;
        recenter_now = 1'b0;
        case (s_q.bus)
            TPI_BUS_IDLE: begin
                s_d.waitreq = 1'b1;
                if (avs_read | avs_write) begin
                    s_d.bus     = TPI_BUS_ANSWER;
                    s_d.waitreq = 1'b0;
                    // read data is held from one read answer to the next
                    if (avs_read) begin
                        s_d.rdata = read_mux(s_q, avs_address);
                    end
                end
            end
            TPI_BUS_ANSWER: begin
                s_d.bus     = TPI_BUS_IDLE;
                s_d.waitreq = 1'b1;
                do_write    = avs_write;
                do_read     = avs_read;
            end
            default: begin
                s_d.bus     = TPI_BUS_IDLE;
                s_d.waitreq = 1'b1;
            end
        endcase

        if (do_write) begin
            case (avs_address)
                REG_CTRL: begin
                    s_d.ctrl = avs_writedata[6:0];
                end
                REG_RECENTER: begin
                    s_d.recenter = avs_writedata[0];
                    recenter_now = ~avs_writedata[0];
                end
                REG_MASK: begin
                    s_d.mask = avs_writedata[3:0];
                end
                default: begin
                end
            endcase
        end

        // phase align buffer
        // ticks on both sides in one cycle raise no fault and keep the fill, except an empty buffer, which gains one
        push_ok   = if_tick & (s_q.fill != PAB_FULL);
        pop_ok    = char_tick & (s_q.fill != 3'h0);
        overflow  = if_tick & ~char_tick & (s_q.fill == PAB_FULL);
        underflow = char_tick & ~if_tick & (s_q.fill == 3'h0);
        pop_word  = s_q.mem[s_q.rd_ptr];

        if (if_tick) begin
            if (push_ok | pop_ok) begin
                s_d.mem[s_q.wr_ptr] = s_q.din3;
                s_d.wr_ptr          = s_q.wr_ptr + 2'h1;
            end
        end
        if (pop_ok) begin
            s_d.rd_ptr = s_q.rd_ptr + 2'h1;
        end
        case ({if_tick & (push_ok | pop_ok), pop_ok})
            2'b10:   s_d.fill = s_q.fill + 3'h1;
            2'b01:   s_d.fill = s_q.fill - 3'h1;
            default: s_d.fill = s_q.fill;
        endcase
        if (recenter_now) begin
            s_d.wr_ptr = PAB_CENTER[1:0];
            s_d.rd_ptr = 2'h0;
            s_d.fill   = PAB_CENTER;
        end

        // sticky align error, a new fault wins over its clear
        if (overflow | underflow) begin
            s_d.pab_err = 1'b1;
        end else if (word_sync_sent | recenter_now) begin
            s_d.pab_err = 1'b0;
        end

        // character hand-off to the encoder or the shifter
        s_d.char_valid = pop_ok;
        if (pop_ok) begin
            s_d.char_out.code = pop_word;
            if (s_q.ctrl[CTRL_ENC_BYPASS]) begin
                s_d.char_out.kind = TPI_KIND_RAW;
            end else begin
                s_d.char_out.code = {2'b00, pop_word[7:0]};
                case (pop_word[9:8])
                    2'b00:   s_d.char_out.kind = TPI_KIND_DATA;
                    2'b01:   s_d.char_out.kind = TPI_KIND_SPECIAL;
                    default: s_d.char_out.kind = TPI_KIND_REPLACE;
                endcase
            end
        end

        // self-test pass pulse, one character period long
        built_in_selftest_last = s_q.ctrl[CTRL_RX_CLK_SEL] ? BUILT_IN_SELFTEST_LAST_RX : BUILT_IN_SELFTEST_LAST_REF;
        built_in_selftest_wrap = 1'b0;
        if (s_q.ctrl[CTRL_SELFTEST_EN]) begin
            s_d.built_in_selftest_cnt   = 10'h0;
            s_d.built_in_selftest_pulse = 1'b0;
        end else if (char_tick) begin
            built_in_selftest_wrap      = (s_q.built_in_selftest_cnt >= built_in_selftest_last);
            s_d.built_in_selftest_cnt   = built_in_selftest_wrap ? 10'h0 : s_q.built_in_selftest_cnt + 10'h1;
            s_d.built_in_selftest_pulse = built_in_selftest_wrap;
        end

        // reference clock watchdog
        // saturates, so a stopped reference keeps the error forced
        if (ref_rise | ref_fall) begin
            s_d.ref_idle = 8'h0;
        end else if (s_q.ref_idle != REF_LOSS_LIM) begin
            s_d.ref_idle = s_q.ref_idle + 8'h1;
        end
        ref_lost = (s_q.ref_idle == REF_LOSS_LIM);

        pll_down = ~s_q.ctrl[CTRL_OUT1_EN] & ~s_q.ctrl[CTRL_OUT2_EN];

        // error output follows the align error and the self-test pulse, except when
        // the synthesizer is down or the reference is gone
        if (pll_down | ref_lost) begin
            s_d.err = 1'b1;
        end else if (char_tick | overflow | underflow | recenter_now | word_sync_sent) begin
            s_d.err = s_d.pab_err | s_d.built_in_selftest_pulse;
        end else begin
            s_d.err = s_q.pab_err | s_q.built_in_selftest_pulse;
        end

        // sticky events, write one to clear, set wins
        ev_set = 4'h0;
        ev_set[EV_OVERFLOW]  = overflow;
        ev_set[EV_UNDERFLOW] = underflow;
        ev_set[EV_BUILT_IN_SELFTEST_PASS] = built_in_selftest_wrap;
        ev_set[EV_REF_LOSS]  = ref_lost & ~s_q.ref_idle[0];
        if (do_write && avs_address == REG_EVENTS) begin
            s_d.events = (s_q.events & ~avs_writedata[3:0]) | ev_set;
        end else begin
            s_d.events = s_q.events | ev_set;
        end
        s_d.irq = |(s_d.events & s_d.mask);

        if (do_read) begin
            s_d.rdata = s_q.rdata;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q          <= '0;
            s_q.bus      <= TPI_BUS_IDLE;
            s_q.waitreq  <= 1'b1;
            s_q.ctrl     <= CTRL_RESET;
            s_q.recenter <= 1'b1;
            s_q.wr_ptr   <= PAB_CENTER[1:0];
            s_q.fill     <= PAB_CENTER;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign enc_char_out    = s_q.char_out;
    assign enc_char_valid  = s_q.char_valid;
    assign tx_error_flag   = s_q.err;
    assign irq             = s_q.irq;

endmodule : tpi_tx_input

// ### tpi_props.sv
// port checker of the transmit character input block
// assumes it is bound onto tpi_tx_input
`timescale 1ns/100ps
module tpi_props
    import tpi_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        word_sync_sent,
    input wire tpi_char_t   enc_char_out,
    input wire logic        enc_char_valid,
    input wire logic        tx_error_flag
);
    logic [6:0] ctrl_q;
    logic       wr_ok;
    logic       quiet;
    assign wr_ok = avs_write && !avs_waitrequest;
    // error may only fall with self-test off and an output enabled
    assign quiet = ctrl_q[CTRL_SELFTEST_EN] && (ctrl_q[4:3] != 2'b00);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ok && avs_address == REG_CTRL) begin
            ctrl_q <= avs_writedata[6:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    AST_BUS_ANSWER: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_VALID_PULSE: assert property (enc_char_valid |=> !enc_char_valid)
        else $error("character valid too long");
    AST_OUT_HOLD: assert property (!enc_char_valid |-> $stable(enc_char_out))
        else $error("character moved without valid");
    AST_ENC_CODE: assert property (
        enc_char_valid && enc_char_out.kind != TPI_KIND_RAW |-> enc_char_out.code[9:8] == 2'b00)
        else $error("coded character carries control bits");
    AST_PLL_DOWN: assert property (
        wr_ok && avs_address == REG_CTRL && avs_writedata[4:3] == 2'b00 |-> ##[1:20] tx_error_flag)
        else $error("error not raised with outputs off");
    AST_RECENTER: assert property (
        wr_ok && avs_address == REG_RECENTER && !avs_writedata[0] && quiet
        |-> ##[1:20] !tx_error_flag)
        else $error("recenter left error high");
    AST_WORD_SYNC: assert property (word_sync_sent && quiet |-> ##[1:20] !tx_error_flag)
        else $error("word sync left error high");
endmodule : tpi_props

bind tpi_tx_input tpi_props u_props (
    .core_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_waitrequest, .word_sync_sent, .enc_char_out, .enc_char_valid, .tx_error_flag
);

// ### tpi_host_model.sv
// host character source: interface clock and a counting character stream
// assumes the bench sets run and fast; the clock rests low when stopped
`timescale 1ns/100ps
module tpi_host_model (
    input  wire logic run,
    input  wire logic fast,
    output logic      tx_input_clock,
    output logic [7:0] tx_char_in,
    output logic [1:0] tx_ctrl_in
);
    initial begin
        tx_input_clock = 1'b0;
        tx_char_in     = 8'h00;
        #5;
        forever begin
            #(fast ? 50.0 : 62.5);
            tx_input_clock = run ? !tx_input_clock : 1'b0;
        end
    end
    // change half a period after each capture edge
    always @(negedge tx_input_clock) begin
        tx_char_in <= tx_char_in + 8'h01;
    end
    assign tx_ctrl_in = tx_char_in[1:0];
endmodule : tpi_host_model

// ### tb_top.sv
// self-checking bench of the transmit character input block
// assumes the host model and the bound port checker
`timescale 1ns/100ps
module tb_top
    import tpi_pkg::*;
;
    typedef struct packed {
        logic        wr;
        logic [4:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic        e;
    } tpi_row_t;
    logic        core_clk = 1'b0, reset_n = 1'b0, ref_clock = 1'b0, rx_recovered_clock = 1'b0;
    logic        avs_read = 1'b0, avs_write = 1'b0, word_sync_sent = 1'b0;
    logic        run = 1'b1, fast = 1'b0, mon = 1'b0, byp = 1'b0;
    logic        avs_waitrequest, tx_input_clock, enc_char_valid, tx_error_flag, irq;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [7:0]  tx_char_in, c, prev;
    logic [1:0]  tx_ctrl_in;
    tpi_char_t   enc_char_out, ex;
    int          skip, a, nref = 0, nrx = 0, n_fail = 0, num_checks = 0;
    logic [31:0] modes [3] = '{32'h1c, 32'h3c, 32'h1d};
    tpi_row_t    rows [9] = '{
        '{1'b0, REG_CTRL, 32'h0, 32'h1c, 1'b0}, '{1'b0, REG_RECENTER, 32'h0, 32'h1, 1'b0},
        '{1'b1, REG_MASK, 32'hffffffff, 32'h0, 1'b0}, '{1'b0, REG_MASK, 32'h0, 32'hf, 1'b0},
        '{1'b1, 5'h14, 32'hffffffff, 32'h0, 1'b0}, '{1'b0, 5'h14, 32'h0, 32'h0, 1'b0},
        '{1'b0, REG_EVENTS, 32'h0, 32'h0, 1'b0}, '{1'b1, REG_CTRL, 32'h4, 32'h0, 1'b1},
        '{1'b1, REG_CTRL, 32'h1c, 32'h0, 1'b0}};

    always #5 core_clk = ~core_clk;
    always #62.5 ref_clock = ~ref_clock;
    initial #30 forever #62.5 rx_recovered_clock = ~rx_recovered_clock;
    always @(posedge ref_clock) nref++;
    always @(posedge rx_recovered_clock) nrx++;

    tpi_host_model host (.run, .fast, .tx_input_clock, .tx_char_in, .tx_ctrl_in);
    tpi_tx_input dut (
        .core_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .tx_input_clock, .ref_clock, .rx_recovered_clock,
        .tx_char_in, .tx_ctrl_in, .word_sync_sent, .enc_char_out, .enc_char_valid,
        .tx_error_flag, .irq);

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // outputs are looked at on the falling edge, where they have settled
    task automatic wait_err(input logic v, input int lim);
        int i;
        i = 0;
        do begin
            @(negedge core_clk);
            i++;
        end while (tx_error_flag !== v && i < lim);
        if (tx_error_flag !== v) begin
            chk(32'h0, 32'h1);
            report_and_stop();
        end
        @(posedge core_clk);
    endtask : wait_err
    task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] d);
        int i;
        avs_address   <= ad;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        i = 0;
        do begin
            @(negedge core_clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        if (avs_waitrequest !== 1'b0) begin
            chk(32'h0, 32'h1);
            report_and_stop();
        end
        q = avs_readdata;
        @(posedge core_clk);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic recenter;
        bus(1'b1, REG_RECENTER, 32'h0);
        wait_err(1'b0, 40);
        bus(1'b1, REG_RECENTER, 32'h1);
    endtask : recenter

    // stream monitor: host counts up, control equals the two low bits
    always @(negedge core_clk) begin
        if (mon && enc_char_valid === 1'b1) begin
            c = enc_char_out.code[7:0];
            ex.kind = byp ? TPI_KIND_RAW : c[1] ? TPI_KIND_REPLACE
                    : c[0] ? TPI_KIND_SPECIAL : TPI_KIND_DATA;
            ex.code = {byp ? c[1:0] : 2'b00, c};
            if (skip > 0) skip = skip - 1;
            else begin
                chk({20'h0, enc_char_out}, {20'h0, ex});
                chk({24'h0, c}, {24'h0, prev + 8'h01});
            end
            prev = c;
        end
    end

    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) chk(q, rows[i].q);
            repeat (20) @(posedge core_clk);
            chk({31'h0, tx_error_flag}, {31'h0, rows[i].e});
        end
        $display("register table done");
        foreach (modes[i]) begin
            bus(1'b1, REG_CTRL, modes[i]);
            byp  <= modes[i][CTRL_ENC_BYPASS];
            skip <= 4;
            mon  <= 1'b1;
            repeat (600) @(posedge core_clk);
            chk(skip, 32'h0);
            mon  <= 1'b0;
        end
        bus(1'b1, REG_CTRL, 32'h1c);
        recenter();
        $display("character stream done");
        bus(1'b1, REG_MASK, 32'h3);
        fast <= 1'b1;
        wait_err(1'b1, 2000);
        fast <= 1'b0;
        repeat (200) @(posedge core_clk);
        chk({30'h0, tx_error_flag, irq}, 32'h3);
        recenter();
        bus(1'b0, REG_EVENTS, 32'h0);
        chk(q & 32'h1, 32'h1);
        bus(1'b1, REG_EVENTS, 32'hf);
        bus(1'b0, REG_EVENTS, 32'h0);
        chk({q[30:0], irq}, 32'h0);
        fast <= 1'b1;
        wait_err(1'b1, 2000);
        fast <= 1'b0;
        run  <= 1'b0;
        repeat (25) @(posedge core_clk);
        run  <= 1'b1;
        repeat (200) @(posedge core_clk);
        chk({31'h0, tx_error_flag}, 32'h1);
        word_sync_sent <= 1'b1;
        @(posedge core_clk);
        word_sync_sent <= 1'b0;
        wait_err(1'b0, 40);
        // half rate on the character side only drains twice as fast
        bus(1'b1, REG_CTRL, 32'h5c);
        wait_err(1'b1, 200);
        bus(1'b0, REG_EVENTS, 32'h0);
        chk({31'h0, q[EV_UNDERFLOW]}, 32'h1);
        bus(1'b1, REG_CTRL, 32'h1d);
        recenter();
        $display("align buffer faults done");
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, REG_CTRL, i ? 32'h1a : 32'h18);
            recenter();
            wait_err(1'b1, 8000);
            wait_err(1'b0, 40);
            wait_err(1'b1, 8000);
            a = i ? nrx : nref;
            wait_err(1'b0, 40);
            chk((i ? nrx : nref) - a, 32'h1);
            wait_err(1'b1, 8000);
            chk((i ? nrx : nref) - a, i ? 32'h20f : 32'h1ff);
        end
        $display("self-test pulses done");
        report_and_stop();
    end
endmodule : tb_top
